// ---- gtm_timer.sv ----
/*
 * Dual 16-bit general timer: one-shot, periodic, edge count, edge time
 * and PWM for two identical halves, with a plain register port.
 * Assumes the register master keeps strobes one cycle long and the
 * capture/compare pins are driven by the outside world.
 */
// Design decisions made here: the placing of the registers and the strobed register port.
// Summary of operation
// RULE1: Configuration value 0x4 enables independent 16-bit operation of both halves.
// RULE2: One-shot/periodic halves count down 16 bits with optional 8-bit prescaler.
// RULE3: Enabled counter counts down; after zero reloads interval and prescale.
// RULE4: One-shot clears enable after timeout; periodic keeps counting.
// RULE5: Zero sets raw timeout flag until software clears it.
// RULE6: Unmasked timeout shows in masked status and raises interrupt.
// RULE7: Output trigger enable gives one-cycle pulse at zero.
// RULE8: Interval-load write while running loads counter next cycle.
// RULE9: Stall bit freezes counter while set.
// RULE10: Capture-mode bit zero selects edge count; event field picks edges.
// RULE11: Each selected edge decrements count until it equals match.
// RULE12: Match sets flags, reloads, clears enable, ignores further edges.
// RULE13: Edge time free-runs from interval load, no prescaler.
// RULE14: Capture-mode bit one selects edge time; event field picks edges.
// RULE15: Selected edge copies count to value register and sets capture flag.
// RULE16: Edge time keeps running after capture, reloads at zero.
// RULE17: Captured value holds until next selected edge.
// RULE18: PWM uses alternate bit 1, capture bit 0, mode 2.
// RULE19: PWM counts down and reloads with no flags or interrupts.
// RULE20: PWM output rises at interval start value, falls at match.
// RULE21: Output-level bit inverts PWM waveform.
// RULE22: Mode field 1 selects one-shot, 2 periodic.
// RULE23: Mode field 3 selects capture; capture bit picks count or time.
// RULE24: Pin input is synchronised and edges found on the synchronised level.
`timescale 1ns/1ps
`include "gtm_regs.svh"

module gtm_timer (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic [1:0]  ccp_in,
    output logic      [1:0]  ccp_out,
    output logic      [1:0]  ccp_oe_out,
    output logic      [1:0]  trig_out,
    output logic             irq_out
);
    import gtm_pkg::*;

    gtm_state_type st_ff;
    gtm_state_type nxt_st;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [15:0] ev;
        logic [15:0] clr;
        logic [15:0] dec;
        logic        rise;
        logic        fall;
        logic        edge_hit;
        logic        run;
        logic        on16;
        int          b;
        ev       = '0;
        clr      = '0;
        dec      = '0;
        rise     = 1'b0;
        fall     = 1'b0;
        edge_hit = 1'b0;
        run      = 1'b0;
        b        = 0;
        on16     = (st_ff.cfg == `GTM_CFG_16BIT); // RULE1
        nxt_st       = st_ff;
        nxt_st.rdata = '0;

        for (int n = 0; n < 2; n++) begin
            b = n * `GTM_HALF_STRIDE;
            nxt_st.half[n].sync1 = ccp_in[n]; // RULE24
            nxt_st.half[n].sync2 = st_ff.half[n].sync1;
            nxt_st.half[n].prev  = st_ff.half[n].sync2;
            nxt_st.half[n].trig  = 1'b0; // RULE7
            rise = st_ff.half[n].sync2 & ~st_ff.half[n].prev; // RULE24
            fall = ~st_ff.half[n].sync2 & st_ff.half[n].prev;
            if (st_ff.half[n].evt == `GTM_EVT_RISE) begin // RULE10 RULE14
                edge_hit = rise;
            end else if (st_ff.half[n].evt == `GTM_EVT_FALL) begin
                edge_hit = fall;
            end else begin
                edge_hit = rise | fall;
            end
            run = st_ff.half[n].en & on16 & ~st_ff.half[n].stall; // RULE9
            dec = st_ff.half[n].cnt - `GTM_CNT_STEP;

            if (run) begin
                if (st_ff.half[n].mode == GTM_MODE_CAPTURE && !st_ff.half[n].cmr
                    && !st_ff.half[n].ams) begin
                    if (edge_hit) begin // RULE11
                        if (dec == st_ff.half[n].match) begin // RULE12
                            ev[b + `GTM_INT_MATCH] = 1'b1;
                            nxt_st.half[n].cnt     = st_ff.half[n].ilr;
                            nxt_st.half[n].en      = 1'b0;
                        end else begin
                            nxt_st.half[n].cnt = dec;
                        end
                    end
                end else if (st_ff.half[n].mode == GTM_MODE_CAPTURE
                             && !st_ff.half[n].ams) begin
                    if (st_ff.half[n].cnt == `GTM_CNT_ZERO) begin // RULE16
                        nxt_st.half[n].cnt = st_ff.half[n].ilr;
                    end else begin
                        nxt_st.half[n].cnt = dec; // RULE13
                    end
                    if (edge_hit) begin // RULE15 RULE17
                        nxt_st.half[n].cap   = st_ff.half[n].cnt;
                        ev[b + `GTM_INT_CAP] = 1'b1;
                    end
                end else if (st_ff.half[n].mode == GTM_MODE_ONESHOT
                             || st_ff.half[n].mode == GTM_MODE_PERIODIC) begin
                    if (st_ff.half[n].ps != `GTM_PS_ZERO) begin // RULE2
                        nxt_st.half[n].ps = st_ff.half[n].ps - `GTM_PS_STEP;
                    end else begin
                        nxt_st.half[n].ps = st_ff.half[n].pr;
                        if (st_ff.half[n].cnt == `GTM_CNT_ZERO) begin // RULE3
                            nxt_st.half[n].cnt = st_ff.half[n].ilr;
                            if (!st_ff.half[n].ams) begin // RULE19
                                ev[b + `GTM_INT_TO]  = 1'b1; // RULE5
                                nxt_st.half[n].trig  = st_ff.half[n].ote; // RULE7
                                if (st_ff.half[n].mode == GTM_MODE_ONESHOT) begin
                                    nxt_st.half[n].en = 1'b0; // RULE4
                                end
                            end
                        end else begin
                            nxt_st.half[n].cnt = dec;
                        end
                    end
                end
            end

            // PWM needs alternate bit, capture bit clear and periodic mode.
            if (st_ff.half[n].ams && !st_ff.half[n].cmr
                && st_ff.half[n].mode == GTM_MODE_PERIODIC && run) begin // RULE18
                if (st_ff.half[n].cnt == st_ff.half[n].ilr) begin // RULE20
                    nxt_st.half[n].pwm = 1'b1;
                end else if (st_ff.half[n].cnt == st_ff.half[n].match) begin
                    nxt_st.half[n].pwm = 1'b0;
                end
            end else if (!st_ff.half[n].ams) begin
                nxt_st.half[n].pwm = 1'b0;
            end
        end

        // Software writes override the counting above.
        if (wr_in) begin
            unique case (addr_in)
                `GTM_OFS_CFG:    nxt_st.cfg = wdata_in[2:0];
                `GTM_OFS_AMODE, `GTM_OFS_BMODE: begin // RULE22 RULE23
                    b = (addr_in == `GTM_OFS_AMODE) ? 0 : 1;
                    nxt_st.half[b].mode = gtm_mode_type'(wdata_in[`GTM_MODE_TMR +: 2]);
                    nxt_st.half[b].cmr  = wdata_in[`GTM_MODE_CMR];
                    nxt_st.half[b].ams  = wdata_in[`GTM_MODE_AMS];
                end
                `GTM_OFS_CTL: begin
                    for (int n = 0; n < 2; n++) begin
                        b = n * `GTM_HALF_STRIDE;
                        nxt_st.half[n].en    = wdata_in[b + `GTM_CTL_EN];
                        nxt_st.half[n].stall = wdata_in[b + `GTM_CTL_STALL];
                        nxt_st.half[n].evt   = wdata_in[b + `GTM_CTL_EVT +: 2];
                        nxt_st.half[n].ote   = wdata_in[b + `GTM_CTL_OTE];
                        nxt_st.half[n].pwml  = wdata_in[b + `GTM_CTL_PWML];
                    end
                end
                `GTM_OFS_IMR:    nxt_st.imr = wdata_in[15:0];
                `GTM_OFS_ICR:    clr = wdata_in[15:0]; // RULE5
                `GTM_OFS_AILR, `GTM_OFS_BILR: begin // RULE8
                    b = (addr_in == `GTM_OFS_AILR) ? 0 : 1;
                    nxt_st.half[b].ilr = wdata_in[15:0];
                    nxt_st.half[b].cnt = wdata_in[15:0];
                    nxt_st.half[b].ps  = st_ff.half[b].pr;
                end
                `GTM_OFS_AMATCH: nxt_st.half[0].match = wdata_in[15:0];
                `GTM_OFS_BMATCH: nxt_st.half[1].match = wdata_in[15:0];
                `GTM_OFS_APR:    nxt_st.half[0].pr = wdata_in[7:0];
                `GTM_OFS_BPR:    nxt_st.half[1].pr = wdata_in[7:0];
                default: ;
            endcase
        end

        // A flag set in the same cycle as its clear stays set.
        nxt_st.ris = (st_ff.ris & ~clr) | ev; // RULE5

        for (int n = 0; n < 2; n++) begin
            nxt_st.half[n].pin = nxt_st.half[n].pwm ^ nxt_st.half[n].pwml; // RULE21
        end

        if (rd_in) begin
            unique case (addr_in)
                `GTM_OFS_CFG:    nxt_st.rdata = {29'h0, st_ff.cfg};
                `GTM_OFS_AMODE:  nxt_st.rdata = {28'h0, st_ff.half[0].ams,
                                     st_ff.half[0].cmr, st_ff.half[0].mode};
                `GTM_OFS_BMODE:  nxt_st.rdata = {28'h0, st_ff.half[1].ams,
                                     st_ff.half[1].cmr, st_ff.half[1].mode};
                `GTM_OFS_CTL: begin
                    for (int n = 0; n < 2; n++) begin
                        b = n * `GTM_HALF_STRIDE;
                        nxt_st.rdata[b + `GTM_CTL_EN]       = st_ff.half[n].en;
                        nxt_st.rdata[b + `GTM_CTL_STALL]    = st_ff.half[n].stall;
                        nxt_st.rdata[b + `GTM_CTL_EVT +: 2] = st_ff.half[n].evt;
                        nxt_st.rdata[b + `GTM_CTL_OTE]      = st_ff.half[n].ote;
                        nxt_st.rdata[b + `GTM_CTL_PWML]     = st_ff.half[n].pwml;
                    end
                end
                `GTM_OFS_IMR:    nxt_st.rdata = {16'h0, st_ff.imr};
                `GTM_OFS_RIS:    nxt_st.rdata = {16'h0, st_ff.ris};
                `GTM_OFS_MIS:    nxt_st.rdata = {16'h0, st_ff.ris & st_ff.imr}; // RULE6
                `GTM_OFS_AILR:   nxt_st.rdata = {16'h0, st_ff.half[0].ilr};
                `GTM_OFS_BILR:   nxt_st.rdata = {16'h0, st_ff.half[1].ilr};
                `GTM_OFS_AMATCH: nxt_st.rdata = {16'h0, st_ff.half[0].match};
                `GTM_OFS_BMATCH: nxt_st.rdata = {16'h0, st_ff.half[1].match};
                `GTM_OFS_APR:    nxt_st.rdata = {24'h0, st_ff.half[0].pr};
                `GTM_OFS_BPR:    nxt_st.rdata = {24'h0, st_ff.half[1].pr};
                `GTM_OFS_AVAL, `GTM_OFS_BVAL: begin // RULE17
                    b = (addr_in == `GTM_OFS_AVAL) ? 0 : 1;
                    if (st_ff.half[b].mode == GTM_MODE_CAPTURE && st_ff.half[b].cmr) begin
                        nxt_st.rdata = {16'h0, st_ff.half[b].cap};
                    end else begin
                        nxt_st.rdata = {16'h0, st_ff.half[b].cnt};
                    end
                end
                default:         nxt_st.rdata = '0;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
            for (int n = 0; n < 2; n++) begin
                st_ff.half[n].ilr <= `GTM_ILR_RST; // RULE13
                st_ff.half[n].cnt <= `GTM_CNT_RST;
                st_ff.half[n].cap <= `GTM_CNT_RST;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_comb begin
        rdata_out = st_ff.rdata;
        irq_out   = |(st_ff.ris & st_ff.imr); // RULE6
        for (int n = 0; n < 2; n++) begin
            ccp_out[n]    = st_ff.half[n].pin;
            ccp_oe_out[n] = st_ff.half[n].ams & (st_ff.cfg == `GTM_CFG_16BIT);
            trig_out[n]   = st_ff.half[n].trig;
        end
    end

endmodule // gtm_timer

// ---- gtm_regs.svh ----
/*
 * Register offsets, field positions, reset values and codes of the dual
 * 16-bit timer. Assumes a byte-addressed 8-bit register port with one
 * 32-bit word per register.
 */
`ifndef GTM_REGS_SVH
`define GTM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define GTM_OFS_CFG      8'h00
`define GTM_OFS_AMODE    8'h04
`define GTM_OFS_BMODE    8'h08
`define GTM_OFS_CTL      8'h0c
`define GTM_OFS_IMR      8'h18
`define GTM_OFS_RIS      8'h1c
`define GTM_OFS_MIS      8'h20
`define GTM_OFS_ICR      8'h24
`define GTM_OFS_AILR     8'h28
`define GTM_OFS_BILR     8'h2c
`define GTM_OFS_AMATCH   8'h30
`define GTM_OFS_BMATCH   8'h34
`define GTM_OFS_APR      8'h38
`define GTM_OFS_BPR      8'h3c
`define GTM_OFS_AVAL     8'h48
`define GTM_OFS_BVAL     8'h4c

// ****************************************************************
// Field positions
// ****************************************************************
`define GTM_HALF_STRIDE  8
`define GTM_MODE_TMR     0
`define GTM_MODE_CMR     2
`define GTM_MODE_AMS     3
`define GTM_CTL_EN       0
`define GTM_CTL_STALL    1
`define GTM_CTL_EVT      2
`define GTM_CTL_OTE      5
`define GTM_CTL_PWML     6
`define GTM_INT_TO       0
`define GTM_INT_MATCH    1
`define GTM_INT_CAP      2

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define GTM_CFG_16BIT    3'h4
`define GTM_EVT_RISE     2'h0
`define GTM_EVT_FALL     2'h1
`define GTM_ILR_RST      16'hffff
`define GTM_CNT_RST      16'hffff
`define GTM_CNT_ZERO     16'h0000
`define GTM_CNT_STEP     16'h0001
`define GTM_PS_ZERO      8'h00
`define GTM_PS_STEP      8'h01

`endif

// ---- gtm_pkg.sv ----
/*
 * Types of the dual 16-bit timer: mode codes, per-half state and the
 * whole state of the block. Assumes gtm_regs.svh for numeric constants.
 */
package gtm_pkg;

    typedef enum logic [1:0] {
        GTM_MODE_OFF      = 2'b00,
        GTM_MODE_ONESHOT  = 2'b01,
        GTM_MODE_PERIODIC = 2'b10,
        GTM_MODE_CAPTURE  = 2'b11
    } gtm_mode_type;

    typedef struct packed {
        logic         en;
        logic         stall;
        logic [1:0]   evt;
        logic         ote;
        logic         pwml;
        gtm_mode_type mode;
        logic         cmr;
        logic         ams;
        logic [15:0]  ilr;
        logic [7:0]   pr;
        logic [15:0]  match;
        logic [15:0]  cnt;
        logic [7:0]   ps;
        logic [15:0]  cap;
        logic         sync1;
        logic         sync2;
        logic         prev;
        logic         pwm;
        logic         pin;
        logic         trig;
    } gtm_half_type;

    typedef struct packed {
        logic [2:0]             cfg;
        logic [15:0]            ris;
        logic [15:0]            imr;
        logic [31:0]            rdata;
        gtm_half_type [1:0]     half;
    } gtm_state_type;

endpackage

// ---- gtm_pin_drv.sv ----
/* Model of the outside world on one capture/compare input.
   Assumes the bench raises go_in for one cycle per pulse. */
`timescale 1ns/1ps
module gtm_pin_drv #(parameter int HOLD = 4) (
    input  wire logic ref_clk_in,
    input  wire logic go_in,
    output logic      pin_out
);
    int n = 0;
    initial pin_out = 1'b0;
    // Each level is held for HOLD cycles so the synchroniser can see it.
    always @(posedge ref_clk_in) begin
        if (go_in && n == 0) begin
            n <= 2 * HOLD;
            pin_out <= 1'b1;
        end else if (n != 0) begin
            n <= n - 1;
            pin_out <= (n - 1) > HOLD;
        end
    end
endmodule // gtm_pin_drv

// ---- gtm_timer_asserts.sv ----
/* Port checker of the dual timer.
   Assumes the register offsets of gtm_regs.svh. */
`timescale 1ns/1ps
`include "gtm_regs.svh"
module gtm_timer_asserts (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [1:0]  ccp_in,
    input wire logic [1:0]  ccp_out,
    input wire logic [1:0]  ccp_oe_out,
    input wire logic [1:0]  trig_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic [2:0] cfg_ff;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) cfg_ff <= 3'h0;
        else if (wr_in && addr_in == `GTM_OFS_CFG) cfg_ff <= wdata_in[2:0];
    end
    property p_cfg_rb;
        logic [2:0] v;
        (wr_in && addr_in == `GTM_OFS_CFG, v = wdata_in[2:0]) ##2
        (rd_in && addr_in == `GTM_OFS_CFG) |=> rdata_out == {29'h0, v};
    endproperty
    a_cfg_readback: assert property (p_cfg_rb)
        else $error("config readback differs");
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data outside read cycle");
    a_rdata_upper: assert property (rdata_out[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_trig_pulse: assert property (trig_out[0] |=> !trig_out[0])
        else $error("trigger longer than one cycle");
    a_irq_mask_off: assert property (wr_in && addr_in == `GTM_OFS_IMR &&
        wdata_in[15:0] == 16'h0 |=> !irq_out)
        else $error("interrupt with all masked");
    a_oe_alt_off: assert property (wr_in && addr_in == `GTM_OFS_AMODE &&
        !wdata_in[3] |=> !ccp_oe_out[0])
        else $error("pin driven without alternate mode");
    a_oe_alt_on: assert property (wr_in && addr_in == `GTM_OFS_AMODE &&
        wdata_in[3] && cfg_ff == 3'h4 |=> ccp_oe_out[0])
        else $error("pin not driven in alternate mode");
    a_oe_cfg_off: assert property (wr_in && addr_in == `GTM_OFS_CFG &&
        wdata_in[2:0] != 3'h4 |=> ccp_oe_out == 2'h0)
        else $error("pin driven outside split mode");
    cover property (trig_out[0]);
    cover property ($rose(irq_out));
    cover property (ccp_oe_out[0] && $rose(ccp_out[0]));
endmodule // gtm_timer_asserts
bind gtm_timer gtm_timer_asserts gtm_timer_asserts_i (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .ccp_in(ccp_in), .ccp_out(ccp_out),
    .ccp_oe_out(ccp_oe_out), .trig_out(trig_out), .irq_out(irq_out));

// ---- tb_top.sv ----
/* Self-checking bench of the dual timer, half A, and half B in one-shot mode.
   Assumes gtm_pin_drv stands on the capture/compare input. */
`timescale 1ns/1ps
`include "gtm_regs.svh"
module tb_top;
    logic ref_clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, go = 0, irq_out, pin_a;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, v, w;
    logic [1:0] ccp_out, ccp_oe_out, trig_out;
    int n_mismatch = 0, n_checks = 0, n_trig = 0, n_trb = 0, c, t0, hi;
    always #10 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        if (trig_out[0] === 1'b1) n_trig++;
        if (trig_out[1] === 1'b1) n_trb++;
    end
    gtm_timer gtm_timer_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ccp_in({1'b0, pin_a}), .ccp_out(ccp_out), .ccp_oe_out(ccp_oe_out),
        .trig_out(trig_out), .irq_out(irq_out));
    gtm_pin_drv #(.HOLD(4)) gtm_pin_drv_i (.ref_clk_in(ref_clk_in), .go_in(go),
        .pin_out(pin_a));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
        @(posedge ref_clk_in) wr_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge ref_clk_in) rd_in <= 1'b0;
        @(negedge ref_clk_in) d = rdata_out;
        @(posedge ref_clk_in);
    endtask
    task automatic chkr(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(e, d);
    endtask
    task automatic pulse();
        go <= 1'b1;
        @(posedge ref_clk_in) go <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
    endtask
    task automatic wait_trig(output int k);
        k = 0;
        do begin @(negedge ref_clk_in); k++; end while (trig_out[0] !== 1'b1 && k < 2000);
        if (k >= 2000) begin n_mismatch++; print_verdict(); end
        @(posedge ref_clk_in);
    endtask
    task automatic t_reset();
        chkr(`GTM_OFS_CFG, 32'h0);
        chkr(`GTM_OFS_AILR, 32'hffff);
        chkr(`GTM_OFS_AVAL, 32'hffff);
        chkr(`GTM_OFS_APR, 32'h0);
        wr(8'h40, 32'h1234);
        chkr(8'h40, 32'h0);
        chk(32'h0, {30'h0, ccp_oe_out});
        wr(`GTM_OFS_CFG, 32'h3);
        chkr(`GTM_OFS_CFG, 32'h3);
        wr(`GTM_OFS_CFG, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_periodic();
        wr(`GTM_OFS_AMODE, 32'h2); wr(`GTM_OFS_AILR, 32'h2); wr(`GTM_OFS_APR, 32'h1);
        wr(`GTM_OFS_IMR, 32'h1); wr(`GTM_OFS_CTL, 32'h21);
        rd(`GTM_OFS_AVAL, v); repeat (8) @(posedge ref_clk_in); rd(`GTM_OFS_AVAL, w);
        chk(v, w);
        wr(`GTM_OFS_CFG, 32'h4); chkr(`GTM_OFS_CFG, 32'h4);
        wait_trig(c); wait_trig(c);
        chk(32'd6, c);
        chk(32'h1, {31'h0, irq_out});
        chkr(`GTM_OFS_RIS, 32'h1);
        chkr(`GTM_OFS_MIS, 32'h1);
        wr(`GTM_OFS_CTL, 32'h23); rd(`GTM_OFS_AVAL, v);
        repeat (5) @(posedge ref_clk_in); rd(`GTM_OFS_AVAL, w);
        chk(v, w);
        wr(`GTM_OFS_CTL, 32'h21); rd(`GTM_OFS_AVAL, v); rd(`GTM_OFS_AVAL, w);
        chk(32'h1, {31'h0, v !== w});
        wr(`GTM_OFS_APR, 32'h0); wr(`GTM_OFS_AILR, 32'h100); rd(`GTM_OFS_AVAL, v);
        chk(32'hff, v);
        wr(`GTM_OFS_CTL, 32'h0); wr(`GTM_OFS_ICR, 32'h1);
        chkr(`GTM_OFS_RIS, 32'h0);
        chk(32'h0, {31'h0, irq_out});
        $display("test periodic done");
    endtask
    task automatic t_oneshot();
        wr(`GTM_OFS_AMODE, 32'h1); wr(`GTM_OFS_AILR, 32'h3);
        t0 = n_trig; wr(`GTM_OFS_CTL, 32'h21); wait_trig(c);
        repeat (30) @(posedge ref_clk_in);
        chk(32'd1, n_trig - t0);
        chkr(`GTM_OFS_CTL, 32'h20);
        chkr(`GTM_OFS_AVAL, 32'h3);
        chkr(`GTM_OFS_RIS, 32'h1);
        wr(`GTM_OFS_BMODE, 32'h1);
        wr(`GTM_OFS_BILR, 32'h2);
        wr(`GTM_OFS_CTL, 32'h2100);
        repeat (10) @(posedge ref_clk_in);
        chk(32'd1, n_trb);
        chkr(`GTM_OFS_CTL, 32'h2000);
        chkr(`GTM_OFS_BVAL, 32'h2);
        chkr(`GTM_OFS_RIS, 32'h101);
        wr(`GTM_OFS_ICR, 32'h101);
        chkr(`GTM_OFS_RIS, 32'h0);
        $display("test one-shot done");
    endtask
    task automatic t_count();
        wr(`GTM_OFS_ICR, 32'hff); wr(`GTM_OFS_AMODE, 32'h3); wr(`GTM_OFS_IMR, 32'h2);
        for (int e = 0; e < 3; e++) begin
            wr(`GTM_OFS_AILR, 32'h10); wr(`GTM_OFS_AMATCH, 32'h0);
            wr(`GTM_OFS_CTL, (e << 2) | 1); pulse(); pulse();
            repeat (6) @(posedge ref_clk_in);
            chkr(`GTM_OFS_AVAL, (e == 2) ? 32'hc : 32'he);
            wr(`GTM_OFS_CTL, 32'h0);
        end
        wr(`GTM_OFS_AILR, 32'ha); wr(`GTM_OFS_AMATCH, 32'h6); wr(`GTM_OFS_CTL, 32'h9);
        pulse(); pulse(); pulse(); repeat (6) @(posedge ref_clk_in);
        chkr(`GTM_OFS_RIS, 32'h2);
        chkr(`GTM_OFS_MIS, 32'h2);
        chkr(`GTM_OFS_AVAL, 32'ha);
        chkr(`GTM_OFS_CTL, 32'h8);
        $display("test edge count done");
    endtask
    task automatic t_time();
        wr(`GTM_OFS_ICR, 32'hff); wr(`GTM_OFS_AMODE, 32'h7); wr(`GTM_OFS_APR, 32'h1);
        wr(`GTM_OFS_IMR, 32'h4); wr(`GTM_OFS_AILR, 32'hffff); wr(`GTM_OFS_CTL, 32'h1);
        pulse(); rd(`GTM_OFS_AVAL, v); repeat (20) @(posedge ref_clk_in);
        chkr(`GTM_OFS_AVAL, v);
        chkr(`GTM_OFS_RIS, 32'h4);
        pulse(); rd(`GTM_OFS_AVAL, v); pulse(); repeat (6) @(posedge ref_clk_in);
        rd(`GTM_OFS_AVAL, w);
        chk(32'd11, v - w);
        wr(`GTM_OFS_CTL, 32'h0);
        $display("test edge time done");
    endtask
    task automatic t_pwm();
        wr(`GTM_OFS_ICR, 32'hff); wr(`GTM_OFS_IMR, 32'h0); wr(`GTM_OFS_APR, 32'h0);
        wr(`GTM_OFS_AMODE, 32'ha); wr(`GTM_OFS_AILR, 32'h9); wr(`GTM_OFS_AMATCH, 32'h3);
        chk(32'h1, {31'h0, ccp_oe_out[0]});
        t0 = n_trig;
        for (int p = 0; p < 2; p++) begin
            wr(`GTM_OFS_CTL, p ? 32'h61 : 32'h21); repeat (10) @(posedge ref_clk_in);
            hi = 0;
            repeat (20) @(negedge ref_clk_in) if (ccp_out[0] === 1'b1) hi++;
            @(posedge ref_clk_in);
            chk(p ? 32'd8 : 32'd12, hi);
        end
        chk(32'd0, n_trig - t0);
        chkr(`GTM_OFS_RIS, 32'h0);
        $display("test pwm done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        t_reset(); t_periodic(); t_oneshot(); t_count(); t_time(); t_pwm();
        print_verdict();
    end
endmodule // tb_top
